// file: core/caop_alu.sv
`timescale 1ns/1ns
`default_nettype none
module caop_alu
  import caop_pkg::*;
(
  // operands and results
  caop_alu_if.alu x
);
  logic [8:0] diff;
  logic [7:0] corr;
  logic       lo_fix;
  logic       hi_fix;

  // result and flag computation
  always_comb begin
    diff   = {1'b0, x.a} - {1'b0, x.b};
    lo_fix = 1'b0;
    hi_fix = 1'b0;
    corr   = 8'h00;
    x.res  = x.a;
    x.fout = x.fin;
    x.wr   = 1'b0;
    unique case (x.op)
      OP_CCF: x.fout[FC] = ~x.fin[FC];
      OP_CLR: begin
        x.res = 8'h00;
        x.wr  = 1'b1;
      end
      OP_COM: begin
        x.res      = ~x.a;
        x.wr       = 1'b1;
        x.fout[FZ] = (x.res == 8'h00);
        x.fout[FS] = x.res[7];
        x.fout[FV] = 1'b0;
      end
      OP_CP: begin
        x.fout[FC] = diff[8];
        x.fout[FZ] = (diff[7:0] == 8'h00);
        x.fout[FS] = diff[7];
        x.fout[FV] = (x.a[7] ^ x.b[7]) & (diff[7] ^ x.a[7]);
      end
      OP_DA: begin
        if (!x.fin[FD]) begin
          lo_fix = x.fin[FH] | (x.a[3:0] > BCD_DIGIT);
          hi_fix = x.fin[FC] | (x.a > BCD_MAX);
          corr   = (lo_fix ? BCD_LO_ADD : 8'h00) +
                   (hi_fix ? BCD_HI_ADD : 8'h00);
        end else begin
          lo_fix = x.fin[FH];
          hi_fix = x.fin[FC];
          corr   = (lo_fix ? BCD_LO_SUB : 8'h00) +
                   (hi_fix ? BCD_HI_SUB : 8'h00);
        end
        x.res      = x.a + corr;
        x.wr       = 1'b1;
        x.fout[FC] = hi_fix;
        x.fout[FZ] = (x.res == 8'h00);
        x.fout[FS] = x.res[7];
      end
      OP_DEC: begin
        x.res      = x.a - 8'h01;
        x.wr       = 1'b1;
        x.fout[FZ] = (x.res == 8'h00);
        x.fout[FS] = x.res[7];
        x.fout[FV] = (x.a == SIGN_MIN);
      end
      default: x.res = x.a; // branch ops and idle leave flags
    endcase
  end
endmodule : caop_alu
`default_nettype wire

// file: core/caop_alu_if.sv
`timescale 1ns/1ns
`default_nettype none
interface caop_alu_if;
  import caop_pkg::*;
  caop_op_e   op;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] fin;
  logic [7:0] res;
  logic [7:0] fout;
  logic       wr;
  modport core (output op, a, b, fin, input res, fout, wr);
  modport alu  (input op, a, b, fin, output res, fout, wr);
endinterface : caop_alu_if
`default_nettype wire

// file: core/caop_core.sv
`timescale 1ns/1ns
`default_nettype none
module caop_core
  import caop_pkg::*;
#(
  parameter logic [7:0] OPC_CMP_INC_BRANCH_EQ_OP  = DEF_OPC_CMP_INC_BRANCH_EQ_OP,
  parameter logic [7:0] OPC_CMP_INC_BRANCH_NE_OP = DEF_OPC_CMP_INC_BRANCH_NE_OP,
  parameter logic [7:0] OPC_DEC    = DEF_OPC_DEC,
  parameter logic [7:0] OPC_DEC_IR = DEF_OPC_DEC_IR,
  parameter logic [4:0] CYC_MISC   = CYC_OTHER
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);
  caop_alu_if  x ();
  caop_state_e state_q;
  caop_op_e    op_q;
  logic [7:0]  a_q;
  logic [7:0]  b_q;
  logic [7:0]  ptr_q;
  logic [15:0] pc_q;
  logic [7:0]  off_q;
  logic [15:0] dreg_q;
  logic [7:0]  flags_q;
  logic [7:0]  res_q;
  logic [7:0]  waddr_q;
  logic        wen_q;
  logic        ind_q;
  logic        taken_q;
  logic        err_q;
  logic [4:0]  cnt_q;
  logic [4:0]  cyc_q;
  logic [4:0]  el_q;
  logic [31:0] rdata_d;
  logic        acc;
  logic        wr_fire;
  logic        go;
  logic        bad_cmd;
  caop_op_e    cmd_op;

  // opcode to operation class
  function automatic caop_op_e dec_op(input logic [7:0] o);
    caop_op_e r;
    r = OP_NONE;
    if (o == OPC_CCF) r = OP_CCF;
    if (o == OPC_CLR || o == OPC_CLR_IR) r = OP_CLR;
    if (o == OPC_COM || o == OPC_COM_IR) r = OP_COM;
    if (o >= OPC_CP_RR && o <= OPC_CP_IM) r = OP_CP;
    if (o == OPC_CMP_INC_BRANCH_EQ_OP) r = OP_CMP_INC_BRANCH_EQ_OP;
    if (o == OPC_CMP_INC_BRANCH_NE_OP) r = OP_CMP_INC_BRANCH_NE_OP;
    if (o == OPC_DA || o == OPC_DA_IR) r = OP_DA;
    if (o == OPC_DEC || o == OPC_DEC_IR) r = OP_DEC;
    return r;
  endfunction : dec_op

  // indirect forms write through the named register
  function automatic logic is_ind(input logic [7:0] o);
    return o == OPC_CLR_IR || o == OPC_COM_IR ||
           o == OPC_DA_IR || o == OPC_DEC_IR;
  endfunction : is_ind

  // execution length in clock cycles
  function automatic logic [4:0] cycles(input logic [7:0] o,
                                        input logic       eq);
    caop_op_e k;
    k = dec_op(o);
    if (k == OP_CMP_INC_BRANCH_EQ_OP) return eq ? CYC_BR_TAKEN : CYC_BR_NOT;
    if (k == OP_CMP_INC_BRANCH_NE_OP) return eq ? CYC_BR_NOT : CYC_BR_TAKEN;
    if (k == OP_CP && o != OPC_CP_RR) return CYC_CP_LONG;
    if (k == OP_DA || k == OP_DEC) return CYC_MISC;
    return CYC_SHORT;
  endfunction : cycles

  // mapped register addresses
  function automatic logic reg_hit(input logic [11:0] ad);
    return ad == A_DST || ad == A_SRC || ad == A_PTR ||
           ad == A_PC || ad == A_OFFSET || ad == A_CMD ||
           ad == A_STATUS || ad == A_DREG || ad == A_RESULT ||
           ad == A_FLAGS;
  endfunction : reg_hit

  // alu hookup
  assign x.op  = (state_q == S_DONE) ? op_q : OP_NONE;
  assign x.a   = a_q;
  assign x.b   = b_q;
  assign x.fin = flags_q;

  caop_alu u_alu (
    .x (x.alu)
  );

  // bus strobes; one wait state per transfer
  assign acc     = psel & penable;
  assign wr_fire = acc & pready & pwrite;
  assign cmd_op  = dec_op(pwdata[7:0]);
  assign go      = wr_fire & (paddr == A_CMD) & (state_q == S_IDLE) &
                   (cmd_op != OP_NONE);
  assign bad_cmd = wr_fire & (paddr == A_CMD) & ~go;

  // apb handshake and read capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~reg_hit(paddr);
      if (acc & ~pready & ~pwrite) prdata <= rdata_d;
    end
  end

  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      A_DST:    rdata_d[7:0]  = a_q;
      A_SRC:    rdata_d[7:0]  = b_q;
      A_PTR:    rdata_d[7:0]  = ptr_q;
      A_PC:     rdata_d[15:0] = pc_q;
      A_OFFSET: rdata_d[7:0]  = off_q;
      A_CMD:    rdata_d[3:0]  = op_q;
      A_STATUS: rdata_d[3:0]  = {err_q, taken_q, wen_q,
                                 state_q != S_IDLE};
      A_DREG:   rdata_d[15:0] = dreg_q;
      A_RESULT: rdata_d[15:0] = {waddr_q, res_q};
      A_FLAGS:  rdata_d[7:0]  = flags_q;
      default:  rdata_d = 32'h0000_0000;
    endcase
  end

  // operand registers, written only while idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      a_q    <= 8'h00;
      b_q    <= 8'h00;
      off_q  <= 8'h00;
      dreg_q <= 16'h0000;
    end else if (wr_fire && state_q == S_IDLE) begin
      if (paddr == A_DST) a_q <= pwdata[7:0];
      if (paddr == A_SRC) b_q <= pwdata[7:0];
      if (paddr == A_OFFSET) off_q <= pwdata[7:0];
      if (paddr == A_DREG) dreg_q <= pwdata[15:0];
    end
  end

  // sequencer: load count, run, write back
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      op_q    <= OP_NONE;
      ind_q   <= 1'b0;
      cnt_q   <= 5'd0;
      cyc_q   <= 5'd0;
      el_q    <= 5'd0;
    end else begin
      unique case (state_q)
        S_IDLE: if (go) begin
          state_q <= S_EXEC;
          op_q    <= cmd_op;
          ind_q   <= is_ind(pwdata[7:0]);
          cyc_q   <= cycles(pwdata[7:0], a_q == b_q);
          cnt_q   <= cycles(pwdata[7:0], a_q == b_q) - 5'd2;
          el_q    <= 5'd1;
        end
        S_EXEC: begin
          el_q <= el_q + 5'd1;
          if (cnt_q == 5'd0) state_q <= S_DONE;
          else cnt_q <= cnt_q - 5'd1;
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // flag register; completion wins over a software write
  always_ff @(posedge clock) begin
    if (!rst_n) flags_q <= FLAGS_RST;
    else if (state_q == S_DONE) flags_q <= x.fout;
    else if (wr_fire && paddr == A_FLAGS && state_q == S_IDLE)
      flags_q <= pwdata[7:0];
  end

  // result and target address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      res_q   <= 8'h00;
      waddr_q <= 8'h00;
      wen_q   <= 1'b0;
    end else if (state_q == S_DONE) begin
      res_q   <= x.res;
      wen_q   <= x.wr;
      waddr_q <= ind_q ? dreg_q[15:8] : dreg_q[7:0];
    end
  end

  // pointer and program counter for compare-branch
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ptr_q   <= 8'h00;
      pc_q    <= 16'h0000;
      taken_q <= 1'b0;
    end else if (state_q == S_DONE &&
                 (op_q == OP_CMP_INC_BRANCH_EQ_OP || op_q == OP_CMP_INC_BRANCH_NE_OP)) begin
      ptr_q   <= ptr_q + 8'h01;
      taken_q <= (op_q == OP_CMP_INC_BRANCH_EQ_OP) == (a_q == b_q);
      if ((op_q == OP_CMP_INC_BRANCH_EQ_OP) == (a_q == b_q))
        pc_q <= pc_q + {{8{off_q[7]}}, off_q};
    end else if (state_q == S_DONE) begin
      taken_q <= 1'b0;
    end else if (wr_fire && state_q == S_IDLE) begin
      if (paddr == A_PTR) ptr_q <= pwdata[7:0];
      if (paddr == A_PC) pc_q <= pwdata[15:0];
    end
  end

  // sticky refused-command flag; set wins over clear
  always_ff @(posedge clock) begin
    if (!rst_n) err_q <= 1'b0;
    else if (bad_cmd) err_q <= 1'b1;
    else if (wr_fire && paddr == A_STATUS && pwdata[ST_ERR])
      err_q <= 1'b0;
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_done(caop_op_e o);
    state_q == S_DONE && op_q == o;
  endsequence

  sequence s_stable_flags;
    flags_q == $past(flags_q);
  endsequence

  ccf_invert_a: assert property (s_done(OP_CCF) |=>
    flags_q[FC] != $past(flags_q[FC]) &&
    flags_q[6:0] == $past(flags_q[6:0]))
    else $error("carry invert wrong");
  clr_zero_a: assert property (s_done(OP_CLR) |=>
    res_q == 8'h00 && wen_q and s_stable_flags)
    else $error("clear wrong");
  clr_ind_addr_a: assert property (s_done(OP_CLR) and ind_q |=>
    waddr_q == $past(dreg_q[15:8]))
    else $error("indirect target wrong");
  com_value_a: assert property (s_done(OP_COM) |=>
    res_q == ~$past(a_q))
    else $error("invert result wrong");
  com_flags_a: assert property (s_done(OP_COM) |=>
    !flags_q[FV] && flags_q[FZ] == (res_q == 8'h00) &&
    flags_q[FS] == res_q[7] && flags_q[FC] == $past(flags_q[FC]))
    else $error("invert flags wrong");
  cp_flags_a: assert property (s_done(OP_CP) |=>
    !wen_q && flags_q[FC] == ($past(b_q) > $past(a_q)) &&
    flags_q[FZ] == ($past(a_q) == $past(b_q)) &&
    flags_q[FD] == $past(flags_q[FD]))
    else $error("compare flags wrong");
  cpij_ptr_a: assert property (
    s_done(OP_CMP_INC_BRANCH_EQ_OP) or s_done(OP_CMP_INC_BRANCH_NE_OP) |=>
    ptr_q == $past(ptr_q) + 8'h01 and s_stable_flags)
    else $error("branch pointer wrong");
  cpij_pc_a: assert property (
    s_done(OP_CMP_INC_BRANCH_NE_OP) and a_q != b_q |=>
    pc_q == $past(pc_q) + {{8{$past(off_q[7])}}, $past(off_q)})
    else $error("branch target wrong");
  run_len_a: assert property (state_q == S_EXEC && cnt_q == 5'd0 |->
    el_q == cyc_q - 5'd1 && (op_q != OP_CMP_INC_BRANCH_EQ_OP ||
    cyc_q == ((a_q == b_q) ? CYC_BR_TAKEN : CYC_BR_NOT)))
    else $error("run length wrong");
  da_add_a: assert property (s_done(OP_DA) and !flags_q[FD] |=>
    flags_q[FC] == ($past(flags_q[FC]) || $past(a_q) > BCD_MAX))
    else $error("adjust add carry wrong");
  da_sub_a: assert property (s_done(OP_DA) and flags_q[FD] |=>
    s_stable_flags or flags_q[FC] == $past(flags_q[FC]))
    else $error("adjust sub carry wrong");
  da_zero_a: assert property (s_done(OP_DA) |=>
    flags_q[FZ] == (res_q == 8'h00) && flags_q[FS] == res_q[7])
    else $error("adjust flags wrong");
  dec_value_a: assert property (s_done(OP_DEC) |=>
    res_q == $past(a_q) - 8'h01 &&
    flags_q[FV] == ($past(a_q) == SIGN_MIN))
    else $error("decrement wrong");

  // bus handshake: one wait state, single-cycle answer
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("bus wait state wrong");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("bus ready held too long");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("bus error without ready");

  // branch outcome, fall-through and length
  cmp_inc_branch_eq_op_taken_a: assert property (
    s_done(OP_CMP_INC_BRANCH_EQ_OP) and a_q == b_q |=> taken_q &&
    pc_q == $past(pc_q) + {{8{$past(off_q[7])}}, $past(off_q)})
    else $error("equal branch not taken");
  cpij_fall_a: assert property (
    (s_done(OP_CMP_INC_BRANCH_EQ_OP) and a_q != b_q) or
    (s_done(OP_CMP_INC_BRANCH_NE_OP) and a_q == b_q) |=>
    !taken_q && pc_q == $past(pc_q))
    else $error("branch fall-through wrong");
  cmp_inc_branch_ne_op_len_a: assert property (
    state_q == S_EXEC && cnt_q == 5'd0 && op_q == OP_CMP_INC_BRANCH_NE_OP |->
    cyc_q == ((a_q != b_q) ? CYC_BR_TAKEN : CYC_BR_NOT))
    else $error("not-equal branch length wrong");

  // compare sign and overflow give the signed order
  cp_signed_a: assert property (s_done(OP_CP) |=>
    (flags_q[FS] ^ flags_q[FV]) ==
    ($signed($past(a_q)) < $signed($past(b_q))))
    else $error("compare sign or overflow wrong");

  // bcd corrections for single table rows
  da_none_a: assert property (
    s_done(OP_DA) and !flags_q[FD] && !flags_q[FC] && !flags_q[FH] &&
    a_q[3:0] <= BCD_DIGIT && a_q <= BCD_MAX |=>
    res_q == $past(a_q) && !flags_q[FC])
    else $error("adjust applied needless correction");
  da_low_a: assert property (
    s_done(OP_DA) and !flags_q[FD] && !flags_q[FC] && !flags_q[FH] &&
    a_q[3:0] > BCD_DIGIT && a_q <= BCD_MAX |=>
    res_q == $past(a_q) + BCD_LO_ADD && !flags_q[FC])
    else $error("adjust low digit wrong");
  da_sub_both_a: assert property (
    s_done(OP_DA) and flags_q[FD] && flags_q[FC] && flags_q[FH] |=>
    res_q == 8'($past(a_q) + BCD_LO_SUB + BCD_HI_SUB))
    else $error("adjust subtract correction wrong");

  // flags kept where the operation leaves them alone
  dec_flags_a: assert property (s_done(OP_DEC) |=>
    flags_q[FC] == $past(flags_q[FC]) &&
    flags_q[FD:FH] == $past(flags_q[FD:FH]) &&
    flags_q[FZ] == (res_q == 8'h00) && flags_q[FS] == res_q[7])
    else $error("decrement flags wrong");
  exec_flags_a: assert property (
    state_q == S_EXEC |=> flags_q == $past(flags_q))
    else $error("flags moved during execution");

  // busy refusal and sticky error
  busy_hold_a: assert property (state_q != S_IDLE |=>
    a_q == $past(a_q) && b_q == $past(b_q))
    else $error("operand changed while busy");
  err_set_a: assert property (bad_cmd |=> err_q)
    else $error("refused command not flagged");
endmodule : caop_core
`default_nettype wire

// file: core/caop_pkg.sv
// Summary of operation
// - carry invert opcode flips carry flag
// - zero destination, flags untouched, four cycles
// - indirect clear zeroes the pointed register
// - ones invert replaces destination with inverse
// - invert sets zero, sign; clears overflow
// - compare subtracts only for flags
// - compare carry borrow, zero, sign, overflow
// - equal branch adds offset, pointer increments
// - not-equal branch on difference, flags kept
// - branch ops take eighteen or sixteen cycles
// - branch offset is a signed byte
// - adjust after add adds 00/06/60/66
// - adjust after subtract adds 00/fa/a0/9a
// - adjust sets carry, zero, sign flags
// - decrement subtracts one, sets zero sign overflow
package caop_pkg;
  // register byte addresses; flags index times four
  localparam logic [7:0]  FLAGS_IDX  = 8'hd5;
  localparam logic [11:0] A_FLAGS    = {2'b00, FLAGS_IDX, 2'b00};
  localparam logic [11:0] A_DST      = 12'h000;
  localparam logic [11:0] A_SRC      = 12'h004;
  localparam logic [11:0] A_PTR      = 12'h008;
  localparam logic [11:0] A_PC       = 12'h00c;
  localparam logic [11:0] A_OFFSET   = 12'h010;
  localparam logic [11:0] A_CMD      = 12'h014;
  localparam logic [11:0] A_STATUS   = 12'h018;
  localparam logic [11:0] A_DREG     = 12'h01c;
  localparam logic [11:0] A_RESULT   = 12'h020;
  // flag bit positions and reset values
  localparam int FC = 7;
  localparam int FZ = 6;
  localparam int FS = 5;
  localparam int FV = 4;
  localparam int FD = 3;
  localparam int FH = 2;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam int ST_ERR = 3;
  // opcodes
  localparam logic [7:0] OPC_CCF    = 8'hef;
  localparam logic [7:0] OPC_CLR    = 8'hb0;
  localparam logic [7:0] OPC_CLR_IR = 8'hb1;
  localparam logic [7:0] OPC_COM    = 8'h60;
  localparam logic [7:0] OPC_COM_IR = 8'h61;
  localparam logic [7:0] OPC_CP_RR  = 8'ha2;
  localparam logic [7:0] OPC_CP_RI  = 8'ha3;
  localparam logic [7:0] OPC_CP_FR  = 8'ha4;
  localparam logic [7:0] OPC_CP_FI  = 8'ha5;
  localparam logic [7:0] OPC_CP_IM  = 8'ha6;
  localparam logic [7:0] OPC_DA     = 8'h40;
  localparam logic [7:0] OPC_DA_IR  = 8'h41;
  // arbitrary defaults for encodings not fixed here
  localparam logic [7:0] DEF_OPC_CMP_INC_BRANCH_EQ_OP  = 8'hc2;
  localparam logic [7:0] DEF_OPC_CMP_INC_BRANCH_NE_OP = 8'hd2;
  localparam logic [7:0] DEF_OPC_DEC    = 8'h00;
  localparam logic [7:0] DEF_OPC_DEC_IR = 8'h01;
  // cycle counts
  localparam logic [4:0] CYC_SHORT    = 5'd4;
  localparam logic [4:0] CYC_CP_LONG  = 5'd6;
  localparam logic [4:0] CYC_BR_TAKEN = 5'd18;
  localparam logic [4:0] CYC_BR_NOT   = 5'd16;
  localparam logic [4:0] CYC_OTHER    = 5'd4;
  // bcd constants
  localparam logic [7:0] BCD_LO_ADD = 8'h06;
  localparam logic [7:0] BCD_HI_ADD = 8'h60;
  localparam logic [7:0] BCD_LO_SUB = 8'hfa;
  localparam logic [7:0] BCD_HI_SUB = 8'ha0;
  localparam logic [7:0] BCD_MAX    = 8'h99;
  localparam logic [3:0] BCD_DIGIT  = 4'h9;
  localparam logic [7:0] SIGN_MIN   = 8'h80;

  typedef enum logic [3:0] {
    OP_NONE, OP_CCF, OP_CLR, OP_COM, OP_CP,
    OP_CMP_INC_BRANCH_EQ_OP, OP_CMP_INC_BRANCH_NE_OP, OP_DA, OP_DEC
  } caop_op_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_DONE = 2'b11
  } caop_state_e;
endpackage : caop_pkg

// file: verification/tb_cpu_alu_clear_compare_bcd_ops.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_cpu_alu_clear_compare_bcd_ops;
  import caop_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  integer      seed = 5;
  logic [64:0] q[$];
  logic [64:0] e;
  logic [7:0]  ops [16] = '{OPC_CCF, OPC_CLR, OPC_CLR_IR, OPC_COM,
    OPC_COM_IR, OPC_CP_RR, OPC_CP_RI, OPC_CP_FR, OPC_CP_FI, OPC_CP_IM,
    OPC_DA, OPC_DA_IR, DEF_OPC_DEC, DEF_OPC_DEC_IR, DEF_OPC_CMP_INC_BRANCH_EQ_OP,
    DEF_OPC_CMP_INC_BRANCH_NE_OP};
  logic [7:0]  o, d, s, f, a, b;
  logic [8:0]  t;

  caop_core i_caop_core (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // clock and run limit
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      finish_test();
    end
  end

  // answer watcher: oldest note against each completed transfer
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      `CHK("pslverr", e[64], pslverr)
      `CHK("prdata", e[31:0], prdata & e[63:32])
    end
  end

  // one apb transfer; the expected answer is noted first
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] dt, input logic [31:0] m,
                     input logic er);
    int k;
    q.push_back({er, m, dt & m});
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [31:0] x,
                    input logic [31:0] m);
    apb(1'b0, ad, x, m, 1'b0);
  endtask : rd

  // expected {result, flags} of one operation
  function automatic logic [15:0] model(input logic [7:0] op, dd, ss, ff);
    logic [7:0] r;
    logic [7:0] n;
    r = dd;
    n = ff;
    case (op)
      OPC_CCF: n[FC] = ~ff[FC];
      OPC_CLR, OPC_CLR_IR: r = 8'h00;
      OPC_COM, OPC_COM_IR: begin
        r = ~dd;
        n[FV] = 1'b0;
      end
      OPC_DA, OPC_DA_IR: begin
        if (ff[FD]) begin
          r = dd + (ff[FH] ? 8'hfa : 8'h00) + (ff[FC] ? 8'ha0 : 8'h00);
        end else begin
          n[FC] = ff[FC] || dd > 8'h99;
          r = dd + ((ff[FH] || dd[3:0] > 4'h9) ? 8'h06 : 8'h00)
                 + (n[FC] ? 8'h60 : 8'h00);
        end
      end
      DEF_OPC_DEC, DEF_OPC_DEC_IR: begin
        r = dd - 8'h01;
        n[FV] = dd == 8'h80;
      end
      DEF_OPC_CMP_INC_BRANCH_EQ_OP, DEF_OPC_CMP_INC_BRANCH_NE_OP: r = dd;
      default: begin
        r = dd - ss;
        n[FC] = ss > dd;
        n[FV] = (dd[7] != ss[7]) && (r[7] != dd[7]);
      end
    endcase
    if (op[7:4] != 4'hb && op != OPC_CCF && op != DEF_OPC_CMP_INC_BRANCH_EQ_OP &&
        op != DEF_OPC_CMP_INC_BRANCH_NE_OP) begin
      n[FZ] = r == 8'h00;
      n[FS] = r[7];
    end
    return {r, n};
  endfunction : model

  // load operands, issue the command, check timing and results
  task automatic run_op(input logic [7:0] op, dd, ss, ff, off);
    logic [15:0] x, dr, pc;
    logic [7:0]  pt;
    logic        w, br, tk;
    int          n;
    x = model(op, dd, ss, ff);
    dr = 16'($random(seed));
    pc = 16'($random(seed));
    pt = 8'($random(seed)) & 8'h7f;
    br = op == DEF_OPC_CMP_INC_BRANCH_EQ_OP || op == DEF_OPC_CMP_INC_BRANCH_NE_OP;
    tk = br && ((dd == ss) ^ (op == DEF_OPC_CMP_INC_BRANCH_NE_OP));
    w = !(br || op == OPC_CCF || op[7:4] == 4'ha);
    n = br ? (tk ? 18 : 16) : ((op[7:4] == 4'ha && op != OPC_CP_RR) ? 6 : 4);
    wr(A_DST, {24'h0, dd});
    wr(A_SRC, {24'h0, ss});
    wr(A_FLAGS, {24'h0, ff});
    wr(A_DREG, {16'h0, dr});
    wr(A_PTR, {24'h0, pt});
    wr(A_PC, {16'h0, pc});
    wr(A_OFFSET, {24'h0, off});
    wr(A_CMD, {24'h0, op});
    repeat (n - 4) @(posedge clock);
    rd(A_STATUS, 32'h1, 32'h1);
    rd(A_STATUS, {29'h0, tk, w, 1'b0}, 32'h7);
    rd(A_FLAGS, {24'h0, x[7:0]},
       (op[7:1] == 7'h20) ? 32'hec : 32'hfc);
    if (w) begin
      rd(A_RESULT, {16'h0, op[0] ? dr[15:8] : dr[7:0], x[15:8]},
         32'hffff);
    end else begin
      rd(A_DST, {24'h0, dd}, 32'hff);
    end
    if (br) begin
      rd(A_PTR, {24'h0, pt + 8'h01}, 32'hff);
      rd(A_PC, {16'h0, pc + (tk ? {{8{off[7]}}, off} : 16'h0)},
         32'hffff);
    end
  endtask : run_op

  // verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(A_FLAGS, {24'h0, FLAGS_RST}, 32'hff);
    rd(A_STATUS, 32'h0, 32'hf);
    apb(1'b0, 12'h100, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 12'h104, 32'h5a, 32'h0, 1'b1);
    $display("test reset and map done");
    for (int i = 0; i < 32; i++) begin
      o = ops[i % 16];
      d = 8'($random(seed));
      s = (i >= 16 && (i % 16 == 5 || i % 16 > 13)) ? d : 8'($random(seed));
      f = 8'($random(seed));
      if (i == 19) d = 8'hff;
      if (i == 28) d = 8'h80;
      if (o[7:1] == 7'h20) begin
        a = {4'($unsigned($random(seed)) % 10),
             4'($unsigned($random(seed)) % 10)};
        b = {4'($unsigned($random(seed)) % 10),
             4'($unsigned($random(seed)) % 10)};
        t = f[FD] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        d = t[7:0];
        f[FC] = t[8];
        f[FH] = f[FD] ? a[3:0] < b[3:0] : 5'(a[3:0]) + 5'(b[3:0]) > 5'd15;
      end
      run_op(o, d, s, f, (i < 16) ? 8'h80 : 8'h7f);
    end
    $display("test operations done");
    wr(A_DST, 32'h11);
    wr(A_SRC, 32'h22);
    wr(A_FLAGS, 32'h0);
    wr(A_CMD, {24'h0, DEF_OPC_CMP_INC_BRANCH_EQ_OP});
    wr(A_DST, 32'h33);
    wr(A_CMD, {24'h0, OPC_CCF});
    repeat (12) @(posedge clock);
    rd(A_DST, 32'h11, 32'hff);
    rd(A_FLAGS, 32'h0, 32'hfc);
    rd(A_STATUS, 32'h8, 32'h9);
    wr(A_STATUS, 32'h8);
    rd(A_STATUS, 32'h0, 32'h8);
    wr(A_CMD, 32'hff);
    rd(A_STATUS, 32'h8, 32'h8);
    $display("test busy refusal done");
    repeat (4) @(posedge clock);
    finish_test();
  end
endmodule : tb_cpu_alu_clear_compare_bcd_ops
`default_nettype wire
